// ===== src/ulb_core.sv
/*
 * Serial unit with receive error detection, error status clear on read,
 * input noise filter and line break field send and receive.
 * Assumes a 100 MHz sys_clk used as base clock and an Avalon-MM master.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ulb_defs.svh"

module ulb_core
	import ulb_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	// Avalon-MM slave
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Serial pins
	input  wire logic        serial_in_pin,
	output logic             serial_out_pin,
	// Interrupt requests
	output logic             rx_complete_irq,
	output logic             rx_error_irq,
	output logic             tx_complete_irq
);

	ulb_state_type s_reg;
	ulb_state_type s_next;

	// Expected parity bit for a data byte
	function automatic logic par_bit(input logic [1:0] pm,
			input logic [7:0] d);
		logic r;
		r = 1'b0;
		if (pm == ULB_PAR_ODD) begin
			r = ~^d;
		end else if (pm == ULB_PAR_EVEN) begin
			r = ^d;
		end
		return r;
	endfunction : par_bit

	logic        req;
	logic        taken;
	logic        wr_ok;
	logic        tx_on;
	logic        rx_on;
	logic [1:0]  pmode;
	logic        has_par;
	logic [8:0]  rx_bit;
	logic [8:0]  tx_bit;
	logic        pe;
	logic        fe;
	logic        ove;
	logic        err;
	logic [3:0]  frame_end;
	logic [11:0] frm;

	assign avs_waitrequest = req & ~s_reg.ack;
	assign avs_readdata    = s_reg.rdata;
	assign serial_out_pin  = s_reg.txd;
	assign rx_complete_irq = s_reg.irq_rc;
	assign rx_error_irq    = s_reg.irq_re;
	assign tx_complete_irq = s_reg.irq_tc;

	always_comb begin
		s_next = s_reg;
		s_next.irq_rc = 1'b0;
		s_next.irq_re = 1'b0;
		s_next.irq_tc = 1'b0;
		req   = avs_read | avs_write;
		taken = req & s_reg.ack;
		wr_ok = taken & avs_write & avs_byteenable[0];
		tx_on = s_reg.mode[`ULB_MODE_POWER] & s_reg.mode[`ULB_MODE_TXE];
		rx_on = s_reg.mode[`ULB_MODE_POWER] & s_reg.mode[`ULB_MODE_RXE];
		pmode = s_reg.mode[`ULB_MODE_PAR_HI:`ULB_MODE_PAR_LO];
		has_par = (pmode != ULB_PAR_NONE);
		rx_bit = {s_reg.brg_rx, 1'b0} - 9'h001;
		tx_bit = {s_reg.brg_tx, 1'b0} - 9'h001;
		pe = 1'b0;
		fe = 1'b0;
		ove = 1'b0;
		err = 1'b0;
		frame_end = `ULB_DATA_BITS + {3'h0, has_par};
		frm = 12'hFFF;

		// Bus handshake: one wait state, data captured on first cycle
		s_next.ack = req & ~s_reg.ack;
		if (avs_read & ~s_reg.ack) begin
			unique case (avs_address)
				`ULB_OFS_MODE:   s_next.rdata = {24'h00_0000, s_reg.mode};
				`ULB_OFS_LIN:    s_next.rdata = {24'h00_0000, s_reg.lin};
				`ULB_OFS_ERR:    s_next.rdata = {29'h0000_0000, s_reg.errs};
				`ULB_OFS_RXB:    s_next.rdata = {24'h00_0000, s_reg.rx_buf};
				`ULB_OFS_TXSTAT: s_next.rdata = {31'h0000_0000,
						s_reg.tx_st != TX_IDLE};
				`ULB_OFS_BRG_TX: s_next.rdata = {24'h00_0000, s_reg.brg_tx};
				`ULB_OFS_BRG_RX: s_next.rdata = {24'h00_0000, s_reg.brg_rx};
				default:         s_next.rdata = 32'h0000_0000;
			endcase
			if (avs_address == `ULB_OFS_RXB) begin
				s_next.rxb_new = 1'b0;
			end
		end

		// Noise filter behind a two-stage synchroniser
		s_next.sync1  = serial_in_pin;
		s_next.sync2  = s_reg.sync1;
		s_next.prev   = s_reg.sync2;
		if (s_reg.sync2 == s_reg.prev) begin
			s_next.filt = s_reg.sync2;
		end
		s_next.filt_d = s_reg.filt;

		// Transmitter
		unique case (s_reg.tx_st)
			TX_IDLE: begin
				s_next.txd = 1'b1;
				if (s_reg.lin[`ULB_LIN_BTX_TRIG]) begin
					s_next.tx_st  = TX_BREAK;
					s_next.txd    = 1'b0;
					s_next.tx_cnt = tx_bit;
					s_next.tx_idx = `ULB_BTX_BASE - 5'h01 + {2'h0,
						s_reg.lin[`ULB_LIN_LEN_HI:`ULB_LIN_LEN_LO]};
				end
			end
			TX_FRAME: begin
				if (s_reg.tx_cnt != 9'h000) begin
					s_next.tx_cnt = s_reg.tx_cnt - 9'h001;
				end else if (s_reg.tx_idx == 5'h00) begin
					s_next.tx_st  = TX_IDLE;
					s_next.txd    = 1'b1;
					s_next.irq_tc = 1'b1;
				end else begin
					s_next.tx_idx   = s_reg.tx_idx - 5'h01;
					s_next.tx_frame = s_reg.tx_frame >> 1;
					s_next.txd      = s_reg.tx_frame[1];
					s_next.tx_cnt   = tx_bit;
				end
			end
			TX_BREAK: begin
				if (s_reg.tx_cnt != 9'h000) begin
					s_next.tx_cnt = s_reg.tx_cnt - 9'h001;
				end else if (s_reg.tx_idx == 5'h00) begin
					s_next.tx_st  = TX_IDLE;
					s_next.txd    = 1'b1;
					s_next.irq_tc = 1'b1;
					s_next.lin[`ULB_LIN_BTX_TRIG] = 1'b0;
				end else begin
					s_next.tx_idx = s_reg.tx_idx - 5'h01;
					s_next.tx_cnt = tx_bit;
				end
			end
			default: begin
				s_next.tx_st = TX_IDLE;
			end
		endcase
		if (!tx_on) begin
			s_next.tx_st = TX_IDLE;
			s_next.txd   = 1'b1;
			s_next.lin[`ULB_LIN_BTX_TRIG] = 1'b0;
		end

		// Register writes
		if (wr_ok) begin
			unique case (avs_address)
				`ULB_OFS_MODE: begin
					s_next.mode = avs_writedata[7:0] & `ULB_MODE_MASK;
				end
				`ULB_OFS_LIN: begin
					s_next.lin[`ULB_LIN_LEN_HI:`ULB_LIN_LEN_LO] =
						avs_writedata[`ULB_LIN_LEN_HI:`ULB_LIN_LEN_LO];
					s_next.lin[`ULB_LIN_BRX_EN] =
						avs_writedata[`ULB_LIN_BRX_EN] & rx_on;
					s_next.lin[`ULB_LIN_BRX_FLAG] =
						avs_writedata[`ULB_LIN_BRX_EN] & rx_on;
					if (avs_writedata[`ULB_LIN_BTX_TRIG] & tx_on) begin
						s_next.lin[`ULB_LIN_BTX_TRIG] = 1'b1;
					end
				end
				`ULB_OFS_TXB: begin
					if (tx_on && s_reg.tx_st == TX_IDLE &&
							!s_reg.lin[`ULB_LIN_BTX_TRIG]) begin
						frm[8:0] = {avs_writedata[7:0], 1'b0};
						if (has_par) begin
							frm[9] = par_bit(pmode, avs_writedata[7:0]);
						end
						s_next.tx_frame = frm;
						s_next.tx_st    = TX_FRAME;
						s_next.txd      = 1'b0;
						s_next.tx_cnt   = tx_bit;
						s_next.tx_idx   = 5'h09 + {4'h0, has_par} +
							{4'h0, s_reg.mode[`ULB_MODE_STOP2]};
					end
				end
				`ULB_OFS_BRG_TX: s_next.brg_tx = avs_writedata[7:0];
				`ULB_OFS_BRG_RX: s_next.brg_rx = avs_writedata[7:0];
				default: begin
				end
			endcase
		end

		// Read side effects: only bits already reported are cleared
		if (taken && avs_read && avs_address == `ULB_OFS_ERR) begin
			s_next.errs = s_reg.errs & ~s_reg.rdata[2:0];
		end
		if (taken && avs_read && avs_address == `ULB_OFS_RXB &&
				!s_reg.rxb_new) begin
			s_next.rx_full = 1'b0;
		end

		// Receiver, runs on the filtered line
		unique case (s_reg.rx_st)
			RX_IDLE: begin
				if (s_reg.filt_d && !s_reg.filt) begin
					s_next.rx_st  = RX_START;
					s_next.rx_cnt = {1'b0, s_reg.brg_rx} - 9'h001;
				end
			end
			RX_START: begin
				if (s_reg.rx_cnt != 9'h000) begin
					s_next.rx_cnt = s_reg.rx_cnt - 9'h001;
				end else if (!s_reg.filt) begin
					s_next.rx_st   = RX_DATA;
					s_next.rx_idx  = 4'h0;
					s_next.rx_cnt  = rx_bit;
					s_next.brk_len = 5'h01;
				end else begin
					s_next.rx_st = RX_IDLE;
				end
			end
			RX_DATA: begin
				if (s_reg.rx_cnt != 9'h000) begin
					s_next.rx_cnt = s_reg.rx_cnt - 9'h001;
				end else if (s_reg.lin[`ULB_LIN_BRX_EN]) begin
					s_next.rx_cnt = rx_bit;
					if (!s_reg.filt) begin
						if (s_reg.brk_len != 5'h1F) begin
							s_next.brk_len = s_reg.brk_len + 5'h01;
						end
					end else begin
						s_next.rx_st = RX_IDLE;
						if (s_reg.brk_len >= `ULB_BRX_MIN) begin
							s_next.irq_rc = 1'b1;
							s_next.lin[`ULB_LIN_BRX_EN]   = 1'b0;
							s_next.lin[`ULB_LIN_BRX_FLAG] = 1'b0;
						end
						// Short break keeps both bits and stays armed
						// No error flag and no buffer write here
					end
				end else begin
					s_next.rx_cnt = rx_bit;
					s_next.rx_idx = s_reg.rx_idx + 4'h1;
					if (s_reg.rx_idx < `ULB_DATA_BITS) begin
						s_next.rx_shift = {s_reg.filt, s_reg.rx_shift[7:1]};
					end else if (s_reg.rx_idx < frame_end) begin
						s_next.rx_par = s_reg.filt;
					end else begin
						s_next.rx_st = RX_IDLE;
						pe  = (pmode == ULB_PAR_ODD || pmode == ULB_PAR_EVEN)
							&& s_reg.rx_par != par_bit(pmode,
								s_reg.rx_shift);
						fe  = ~s_reg.filt;
						ove = s_reg.rx_full;
						err = pe | fe | ove;
						s_next.errs[`ULB_ERR_PE]  = s_next.errs[`ULB_ERR_PE] | pe;
						s_next.errs[`ULB_ERR_FE]  = s_next.errs[`ULB_ERR_FE] | fe;
						s_next.errs[`ULB_ERR_OVE] =
							s_next.errs[`ULB_ERR_OVE] | ove;
						if (!ove) begin
							s_next.rx_buf  = s_reg.rx_shift;
							s_next.rx_full = 1'b1;
							s_next.rxb_new = 1'b1;
						end
						s_next.irq_rc = ~err | s_reg.mode[`ULB_MODE_MERGE];
						s_next.irq_re = err & ~s_reg.mode[`ULB_MODE_MERGE];
					end
				end
			end
			default: begin
				s_next.rx_st = RX_IDLE;
			end
		endcase
		if (!rx_on) begin
			s_next.rx_st = RX_IDLE;
			s_next.lin[`ULB_LIN_BRX_EN]   = 1'b0;
			s_next.lin[`ULB_LIN_BRX_FLAG] = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s_reg          <= '0;
			s_reg.mode     <= `ULB_MODE_RST;
			s_reg.lin      <= `ULB_LIN_RST;
			s_reg.rx_buf   <= `ULB_RXB_RST;
			s_reg.brg_tx   <= `ULB_BRG_RST;
			s_reg.brg_rx   <= `ULB_BRG_RST;
			s_reg.sync1    <= 1'b1;
			s_reg.sync2    <= 1'b1;
			s_reg.prev     <= 1'b1;
			s_reg.filt     <= 1'b1;
			s_reg.filt_d   <= 1'b1;
			s_reg.tx_frame <= 12'hFFF;
			s_reg.txd      <= 1'b1;
			s_reg.rx_st    <= RX_IDLE;
			s_reg.tx_st    <= TX_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end

endmodule : ulb_core
`default_nettype wire

// ===== src/ulb_defs.svh
/*
 * Register offsets, field positions, reset values and counts of the
 * serial receive error and line break unit.
 * Assumes byte addresses on a 32-bit Avalon-MM bus, one register a word.
 */
`ifndef ULB_DEFS_SVH
`define ULB_DEFS_SVH

// Register byte offsets
`define ULB_OFS_MODE     5'h00
`define ULB_OFS_LIN      5'h04
`define ULB_OFS_ERR      5'h08
`define ULB_OFS_RXB      5'h0C
`define ULB_OFS_TXB      5'h10
`define ULB_OFS_TXSTAT   5'h14
`define ULB_OFS_BRG_TX   5'h18
`define ULB_OFS_BRG_RX   5'h1C

// Mode register fields
`define ULB_MODE_POWER   7
`define ULB_MODE_TXE     6
`define ULB_MODE_RXE     5
`define ULB_MODE_PAR_HI  4
`define ULB_MODE_PAR_LO  3
`define ULB_MODE_STOP2   1
`define ULB_MODE_MERGE   0
`define ULB_MODE_MASK    8'hFB

// Line control register fields
`define ULB_LIN_BRX_FLAG 7
`define ULB_LIN_BRX_EN   6
`define ULB_LIN_BTX_TRIG 5
`define ULB_LIN_LEN_HI   4
`define ULB_LIN_LEN_LO   2

// Error status fields
`define ULB_ERR_OVE      0
`define ULB_ERR_FE       1
`define ULB_ERR_PE       2

// Reset values
`define ULB_MODE_RST     8'h00
`define ULB_LIN_RST      8'h00
`define ULB_RXB_RST      8'hFF
`define ULB_BRG_RST      8'hFF

// Bit counts
`define ULB_DATA_BITS    4'h8
`define ULB_BTX_BASE     5'h0D
`define ULB_BRX_MIN      5'h0B

`endif

// ===== src/ulb_pkg.sv
/*
 * Types of the serial receive error and line break unit.
 * Assumes nothing beyond the defs header of the same unit.
 */
package ulb_pkg;

	typedef enum logic [1:0] {
		ULB_PAR_NONE,
		ULB_PAR_ZERO,
		ULB_PAR_ODD,
		ULB_PAR_EVEN
	} ulb_par_type;

	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} ulb_rx_st_type;
	typedef enum logic [1:0] {TX_IDLE, TX_FRAME, TX_BREAK} ulb_tx_st_type;

	typedef struct packed {
		logic          ack;
		logic [31:0]   rdata;
		logic [7:0]    mode;
		logic [7:0]    lin;
		logic [2:0]    errs;
		logic [7:0]    rx_buf;
		logic          rx_full;
		logic          rxb_new;
		logic [7:0]    brg_tx;
		logic [7:0]    brg_rx;
		logic          sync1;
		logic          sync2;
		logic          prev;
		logic          filt;
		logic          filt_d;
		ulb_rx_st_type rx_st;
		logic [8:0]    rx_cnt;
		logic [3:0]    rx_idx;
		logic [7:0]    rx_shift;
		logic          rx_par;
		logic [4:0]    brk_len;
		ulb_tx_st_type tx_st;
		logic [8:0]    tx_cnt;
		logic [4:0]    tx_idx;
		logic [11:0]   tx_frame;
		logic          txd;
		logic          irq_rc;
		logic          irq_re;
		logic          irq_tc;
	} ulb_state_type;

endpackage : ulb_pkg

// ===== verif/testbench.sv
/*
 * Register-level tests of errors, noise filter and break fields.
 * Assumes ulb_core, ulb_node and the bound checker.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        sys_clk;
	logic        resetn;
	logic [4:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	wire logic   serial_in_pin;
	logic        serial_out_pin;
	logic        rx_complete_irq;
	logic        rx_error_irq;
	logic        tx_complete_irq;
	logic [31:0] rdat;
	int          n_fail = 0;
	int          cmp_count = 0;
	int          n_rc = 0;
	int          n_re = 0;
	int          n_tc = 0;
	int          b_rc = 0;
	int          b_re = 0;
	int          b_tc = 0;
	int          len;

	ulb_core dut_u (.sys_clk, .resetn, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
		.serial_in_pin, .serial_out_pin, .rx_complete_irq, .rx_error_irq,
		.tx_complete_irq);
	ulb_node #(.BIT_CLKS(4)) node_u (.sys_clk, .line_out(serial_in_pin),
		.line_in(serial_out_pin));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		if (rx_complete_irq === 1'b1) n_rc++;
		if (rx_error_irq === 1'b1) n_re++;
		if (tx_complete_irq === 1'b1) n_tc++;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic xfer(input logic wr, input logic [4:0] a,
		input logic [31:0] d);
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		rdat = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : xfer

	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0000_0000);
		chk(rdat, e);
	endtask : rd

	task automatic irqs(input int rc, input int re, input int tc);
		repeat (16) @(posedge sys_clk);
		chk(n_rc - b_rc, rc);
		chk(n_re - b_re, re);
		chk(n_tc - b_tc, tc);
		b_rc = n_rc;
		b_re = n_re;
		b_tc = n_tc;
	endtask : irqs

	function automatic logic [15:0] frm(input logic [7:0] d,
		input logic pbad, input logic stop);
		return {5'h0, stop, ^d ^ pbad, d, 1'b0};
	endfunction : frm

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (20000) @(posedge sys_clk);
		n_fail++;
		tally_and_finish();
	end

	initial begin
		resetn = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 5'h00;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'hF;
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		rd(5'h00, 32'h0000_0000);
		rd(5'h04, 32'h0000_0000);
		rd(5'h08, 32'h0000_0000);
		rd(5'h0C, 32'h0000_00FF);
		rd(5'h1C, 32'h0000_00FF);
		rd(5'h1E, 32'h0000_0000);
		$display("test reset values done");
		xfer(1'b1, 5'h18, 32'h0000_0002);
		xfer(1'b1, 5'h1C, 32'h0000_0002);
		xfer(1'b1, 5'h00, 32'h0000_00F8);
		node_u.glitch();
		irqs(0, 0, 0);
		node_u.send(frm(8'hA5, 1'b0, 1'b1), 11);
		irqs(1, 0, 0);
		rd(5'h08, 32'h0000_0000);
		rd(5'h0C, 32'h0000_00A5);
		$display("test filter and good frame done");
		node_u.send(frm(8'h3C, 1'b1, 1'b1), 11);
		irqs(0, 1, 0);
		rd(5'h08, 32'h0000_0004);
		rd(5'h08, 32'h0000_0000);
		rd(5'h0C, 32'h0000_003C);
		xfer(1'b1, 5'h00, 32'h0000_00F9);
		node_u.send(frm(8'h55, 1'b0, 1'b0), 11);
		irqs(1, 0, 0);
		rd(5'h08, 32'h0000_0002);
		rd(5'h0C, 32'h0000_0055);
		$display("test parity and framing done");
		node_u.send(frm(8'h11, 1'b0, 1'b1), 11);
		irqs(1, 0, 0);
		node_u.send(frm(8'h22, 1'b0, 1'b1), 11);
		irqs(1, 0, 0);
		rd(5'h08, 32'h0000_0001);
		rd(5'h0C, 32'h0000_0011);
		$display("test overrun done");
		xfer(1'b1, 5'h04, 32'h0000_002C);
		node_u.measure_low(len);
		chk(len, 64);
		irqs(0, 0, 1);
		rd(5'h04, 32'h0000_000C);
		chk(serial_out_pin, 1);
		$display("test break send done");
		xfer(1'b1, 5'h04, 32'h0000_0040);
		rd(5'h04, 32'h0000_00C0);
		node_u.send(16'h0400, 11);
		irqs(0, 0, 0);
		rd(5'h04, 32'h0000_00C0);
		node_u.send(16'h1000, 13);
		irqs(1, 0, 0);
		rd(5'h04, 32'h0000_0000);
		rd(5'h08, 32'h0000_0000);
		rd(5'h0C, 32'h0000_0011);
		$display("test break receive done");
		xfer(1'b1, 5'h00, 32'h0000_00F0);
		node_u.send(frm(8'h5A, 1'b1, 1'b1), 11);
		irqs(1, 0, 0);
		rd(5'h08, 32'h0000_0000);
		rd(5'h0C, 32'h0000_005A);
		node_u.send(frm(8'h5A, 1'b0, 1'b1), 11);
		irqs(0, 1, 0);
		rd(5'h08, 32'h0000_0004);
		rd(5'h0C, 32'h0000_005A);
		xfer(1'b1, 5'h00, 32'h0000_00E8);
		node_u.send(frm(8'h03, 1'b1, 1'b1), 11);
		irqs(1, 0, 0);
		rd(5'h08, 32'h0000_0000);
		rd(5'h0C, 32'h0000_0003);
		xfer(1'b1, 5'h10, 32'h0000_0000);
		node_u.measure_low(len);
		chk(len, 40);
		irqs(0, 0, 1);
		rd(5'h14, 32'h0000_0000);
		$display("test parity modes and frame send done");
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire

// ===== verif/ulb_checker.sv
/*
 * Checker of bus handshake, interrupt and serial pin relations.
 * Assumes it is bound to ulb_core and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module ulb_checker (
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        resetn,
	// Register bus
	input wire logic [4:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// Serial pins and interrupts
	input wire logic        serial_in_pin,
	input wire logic        serial_out_pin,
	input wire logic        rx_complete_irq,
	input wire logic        rx_error_irq,
	input wire logic        tx_complete_irq
);
	logic merge_reg;
	logic merge_next;
	logic mode_wr;

	// Shadow of the merge bit
	assign mode_wr = avs_write && !avs_waitrequest && avs_byteenable[0];
	always_comb begin
		merge_next = merge_reg;
		if (mode_wr && avs_address == 5'h00)
			merge_next = avs_writedata[0];
	end
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			merge_reg <= 1'b0;
		else
			merge_reg <= merge_next;
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	sequence s_ack;
		avs_waitrequest ##1 !avs_waitrequest;
	endsequence
	sequence s_idle;
		serial_out_pin [*3];
	endsequence

	AST_BUS_ACK: assert property ($rose(avs_read) |-> s_ack)
		else $error("read not answered after one wait cycle");
	AST_IRQ_EXCL: assert property (!(rx_complete_irq && rx_error_irq))
		else $error("completion and error irq together");
	AST_ERR_ROUTE: assert property (rx_error_irq |-> !merge_reg)
		else $error("error irq while merged");
	AST_ERR_WIDTH: assert property (avs_read && !avs_waitrequest
		&& avs_address == 5'h08 |-> avs_readdata[31:3] == 29'h0000_0000)
		else $error("error status has bits above 2");
	AST_TX_IDLE: assert property (tx_complete_irq |-> s_idle)
		else $error("transmit pin not idle after completion");
	AST_RST_IDLE: assert property ($rose(resetn) |-> serial_out_pin)
		else $error("transmit pin low after reset");
	AST_RC_PULSE: assert property (rx_complete_irq |=> !rx_complete_irq)
		else $error("completion irq longer than a cycle");
	AST_RE_PULSE: assert property (rx_error_irq |=> !rx_error_irq)
		else $error("error irq longer than a cycle");
endmodule : ulb_checker

bind ulb_core ulb_checker chk_u (.sys_clk, .resetn, .avs_address,
	.avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
	.avs_waitrequest, .serial_in_pin, .serial_out_pin, .rx_complete_irq,
	.rx_error_irq, .tx_complete_irq);
`default_nettype wire

// ===== verif/ulb_node.sv
/*
 * Remote serial node: sends frames, breaks and glitches, times breaks.
 * Assumes the bench calls its tasks and shares the unit's clock.
 */
`timescale 1ns/1ps
`default_nettype none
module ulb_node #(
	parameter int BIT_CLKS = 4
) (
	input wire logic sys_clk,
	output var logic line_out,
	input wire logic line_in
);
	initial line_out = 1'b1;

	// Bits LSB first, then idle high
	task automatic send(input logic [15:0] bits, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge sys_clk);
			line_out <= bits[i];
			repeat (BIT_CLKS - 1) @(posedge sys_clk);
		end
		@(posedge sys_clk);
		line_out <= 1'b1;
	endtask : send

	// One-cycle low spike
	task automatic glitch();
		@(posedge sys_clk);
		line_out <= 1'b0;
		@(posedge sys_clk);
		line_out <= 1'b1;
	endtask : glitch

	// Clocks of the next low period
	task automatic measure_low(output int n);
		while (line_in !== 1'b0) @(posedge sys_clk);
		n = 0;
		while (line_in === 1'b0) begin
			n++;
			@(posedge sys_clk);
		end
	endtask : measure_low
endmodule : ulb_node
`default_nettype wire
